// File: hw/ofsw_top.v
// Overclock frequency selection and watchdog control with Wishbone registers
//
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`include "ofsw_consts.vh"
module ofsw_top #(
  parameter [`OFSW_CNT_W-1:0] TICK_CYC  = `OFSW_TICK_CYC,
  parameter [`OFSW_CNT_W-1:0] PULSE_CYC = `OFSW_PULSE_CYC
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  input  wire [4:0]  hardware_freq_straps_i,
  input  wire        reset_output_strap_i,
  input  wire        power_good_n_i,
  input  wire [1:0]  overclock_step_pins_i,
  output wire [4:0]  cpu_table_entry_o,
  output wire [4:0]  gear_sel_o,
  output wire        cpu_use_prog_o,
  output wire        cpu_step_o,
  output wire [8:0]  cpu_n_o,
  output wire [6:0]  cpu_m_o,
  output wire        src_prog_active_o,
  output wire [8:0]  src_n_o,
  output wire        step_load_o,
  output wire        smooth_to_cpu_o,
  output wire        smooth_to_src_o,
  output wire        system_reset_out_n_o
);
  reg        ack_r;
  reg [31:0] dat_r;
  reg [31:0] rd_val;
  reg        strap_override_r;
  reg        dynamic_step_enable_r;
  reg        cpu_prog_en_r;
  reg        src_prog_en_r;
  reg        smooth_manual_r;
  reg        smooth_src_r;
  reg [3:0]  soft_table_index_r;
  reg [8:0]  cpu_prog_multiplier_r;
  reg [6:0]  cpu_prog_divider_r;
  reg [8:0]  serial_ref_prog_multiplier_r;
  reg [8:0]  step_multiplier_one_r;
  reg [8:0]  step_multiplier_two_r;
  reg [8:0]  step_multiplier_three_r;
  reg        watchdog_enable_r;
  reg [2:0]  wd_timer_r;
  reg        wd_scale_r;
  reg        wd_rst_mode_r;
  reg        wd_rec_src_r;
  reg        wd_autorec_r;
  reg        wd_alarm_r;
  reg [8:0]  recov_n_r;
  reg [6:0]  recov_m_r;
  reg        wd_reload_r;
  reg [4:0]  straps_r;
  reg        straps_done_r;
  reg        rst_out_en_r;
  reg [1:0]  step_pins_r;
  reg        step_load_r;
  reg [4:0]  entry_r;
  reg        use_prog_r;
  reg        step_r;
  reg [8:0]  cpu_n_r;
  reg [6:0]  cpu_m_r;
  reg        src_act_r;
  reg [8:0]  src_n_r;
  reg        sm_cpu_r;
  reg        sm_src_r;
  wire       wd_expire;
  wire       wd_active;
  wire       wd_pulse;
  wire        acc     = wb_cyc_i & wb_stb_i;
  wire        wr_done = acc & wb_we_i & ack_r;
  wire [7:0]  adr     = {wb_adr_i[7:2], 2'b00};
  wire [31:0] mask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] wv      = (wb_dat_i & mask) | (rd_val & ~mask);

  function wr_at;
    input [7:0] a;
    input [7:0] target;
    input       done;
    begin
      wr_at = done & (a == target);
    end
  endfunction

  wire wr_ctrl  = wr_at(adr, `OFSW_ADR_CTRL, wr_done);
  wire wr_cpu   = wr_at(adr, `OFSW_ADR_CPU_PROG, wr_done);
  wire wr_src   = wr_at(adr, `OFSW_ADR_SRC_PROG, wr_done);
  wire wr_st1   = wr_at(adr, `OFSW_ADR_STEP1, wr_done);
  wire wr_st2   = wr_at(adr, `OFSW_ADR_STEP2, wr_done);
  wire wr_st3   = wr_at(adr, `OFSW_ADR_STEP3, wr_done);
  wire wr_wd    = wr_at(adr, `OFSW_ADR_WD_CTRL, wr_done);
  wire wr_recov = wr_at(adr, `OFSW_ADR_RECOV_N, wr_done);
  wire en_rise  = wr_wd & wv[`OFSW_B_WATCHDOG_ENABLE] & ~watchdog_enable_r;
  wire t_change = wr_wd & ((wv[`OFSW_F_TIMER_LO+2:`OFSW_F_TIMER_LO] != wd_timer_r) |
                           (wv[`OFSW_B_SCALE] != wd_scale_r));
  wire recover  = wd_expire & ~wd_rst_mode_r;
  // Register readback
  always @* begin
    rd_val = 32'h0000_0000;
    case (adr)
      `OFSW_ADR_CTRL: begin
        rd_val[`OFSW_B_OVERRIDE]                   = strap_override_r;
        rd_val[`OFSW_B_STEP_EN]                    = dynamic_step_enable_r;
        rd_val[`OFSW_B_CPU_PROG]                   = cpu_prog_en_r;
        rd_val[`OFSW_B_SRC_PROG]                   = src_prog_en_r;
        rd_val[`OFSW_B_SM_MANUAL]                  = smooth_manual_r;
        rd_val[`OFSW_B_SM_SRC]                     = smooth_src_r;
        rd_val[`OFSW_F_INDEX_LO+3:`OFSW_F_INDEX_LO] = soft_table_index_r;
      end
      `OFSW_ADR_CPU_PROG: begin
        rd_val[8:0]                        = cpu_prog_multiplier_r;
        rd_val[`OFSW_F_M_LO+6:`OFSW_F_M_LO] = cpu_prog_divider_r;
      end
      `OFSW_ADR_SRC_PROG: rd_val[8:0] = serial_ref_prog_multiplier_r;
      `OFSW_ADR_STEP1:    rd_val[8:0] = step_multiplier_one_r;
      `OFSW_ADR_STEP2:    rd_val[8:0] = step_multiplier_two_r;
      `OFSW_ADR_STEP3:    rd_val[8:0] = step_multiplier_three_r;
      `OFSW_ADR_WD_CTRL: begin
        rd_val[`OFSW_B_WATCHDOG_ENABLE]                      = watchdog_enable_r;
        rd_val[`OFSW_F_TIMER_LO+2:`OFSW_F_TIMER_LO] = wd_timer_r;
        rd_val[`OFSW_B_SCALE]                      = wd_scale_r;
        rd_val[`OFSW_B_RST_MODE]                   = wd_rst_mode_r;
        rd_val[`OFSW_B_REC_SRC]                    = wd_rec_src_r;
        rd_val[`OFSW_B_AUTOREC]                    = wd_autorec_r;
        rd_val[`OFSW_B_ALARM]                      = wd_alarm_r;
      end
      `OFSW_ADR_RECOV_N: rd_val[8:0] = recov_n_r;
      `OFSW_ADR_STATUS: begin
        rd_val[8:0]   = cpu_n_r;
        rd_val[22:16] = cpu_m_r;
        rd_val[24]    = sm_cpu_r;
        rd_val[25]    = sm_src_r;
        rd_val[26]    = wd_active;
        rd_val[27]    = wd_pulse;
        rd_val[28]    = step_r;
      end
      `OFSW_ADR_STRAPS: begin
        rd_val[4:0]   = straps_r;
        rd_val[5]     = rst_out_en_r;
        rd_val[6]     = straps_done_r;
        rd_val[24:16] = src_n_r;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end
  // Wishbone classic slave, one wait state
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= acc & ~ack_r;
      if (acc & ~ack_r & ~wb_we_i)
        dat_r <= rd_val;
    end
  end
  // Frequency selection registers and watchdog recovery
  always @(posedge clk_i) begin
    if (rst_i) begin
      strap_override_r             <= 1'b0;
      dynamic_step_enable_r        <= 1'b0;
      cpu_prog_en_r                <= 1'b0;
      src_prog_en_r                <= 1'b0;
      smooth_manual_r              <= 1'b0;
      smooth_src_r                 <= 1'b0;
      soft_table_index_r           <= 4'h0;
      cpu_prog_multiplier_r        <= 9'h000;
      cpu_prog_divider_r           <= 7'h00;
      serial_ref_prog_multiplier_r <= 9'h000;
      step_multiplier_one_r        <= 9'h000;
      step_multiplier_two_r        <= 9'h000;
      step_multiplier_three_r      <= 9'h000;
    end else begin
      if (wr_ctrl) begin
        strap_override_r      <= wv[`OFSW_B_OVERRIDE];
        dynamic_step_enable_r <= wv[`OFSW_B_STEP_EN];
        cpu_prog_en_r         <= wv[`OFSW_B_CPU_PROG];
        src_prog_en_r         <= wv[`OFSW_B_SRC_PROG];
        smooth_manual_r       <= wv[`OFSW_B_SM_MANUAL];
        smooth_src_r          <= wv[`OFSW_B_SM_SRC];
        soft_table_index_r    <= wv[`OFSW_F_INDEX_LO+3:`OFSW_F_INDEX_LO];
      end
      if (wr_cpu) begin
        cpu_prog_multiplier_r <= wv[8:0];
        cpu_prog_divider_r    <= wv[`OFSW_F_M_LO+6:`OFSW_F_M_LO];
      end
      if (wr_src)
        serial_ref_prog_multiplier_r <= wv[8:0];
      if (wr_st1)
        step_multiplier_one_r <= wv[8:0];
      if (wr_st2)
        step_multiplier_two_r <= wv[8:0];
      if (wr_st3)
        step_multiplier_three_r <= wv[8:0];
      if (recover) begin
        dynamic_step_enable_r <= 1'b0;
        if (cpu_prog_en_r) begin
          if (wd_autorec_r | wd_rec_src_r) begin
            cpu_prog_multiplier_r <= recov_n_r;
            cpu_prog_divider_r    <= recov_m_r;
          end else begin
            cpu_prog_en_r    <= 1'b0;
            strap_override_r <= 1'b0;
          end
        end else if (strap_override_r) begin
          strap_override_r <= 1'b0;
        end
      end
    end
  end
  // Watchdog control registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      watchdog_enable_r <= 1'b0;
      wd_timer_r        <= `OFSW_RST_TIMER;
      wd_scale_r        <= `OFSW_RST_SCALE;
      wd_rst_mode_r     <= 1'b0;
      wd_rec_src_r      <= 1'b0;
      wd_autorec_r      <= `OFSW_RST_AUTOREC;
      wd_alarm_r        <= 1'b0;
      recov_n_r         <= 9'h000;
      recov_m_r         <= 7'h00;
      wd_reload_r       <= 1'b0;
    end else begin
      wd_reload_r <= en_rise | t_change;
      if (wr_wd) begin
        watchdog_enable_r <= wv[`OFSW_B_WATCHDOG_ENABLE];
        wd_timer_r        <= wv[`OFSW_F_TIMER_LO+2:`OFSW_F_TIMER_LO];
        wd_scale_r        <= wv[`OFSW_B_SCALE];
        wd_rst_mode_r     <= wv[`OFSW_B_RST_MODE];
        wd_rec_src_r      <= wv[`OFSW_B_REC_SRC];
        wd_autorec_r      <= wv[`OFSW_B_AUTOREC];
      end
      // Set by expiry wins over a clear in the same cycle
      if (wd_expire)
        wd_alarm_r <= 1'b1;
      else if (wr_wd & wb_sel_i[1] & wb_dat_i[`OFSW_B_ALARM])
        wd_alarm_r <= 1'b0;
      if (wr_recov & ~wd_autorec_r)
        recov_n_r <= wv[8:0];
      if (en_rise) begin
        recov_m_r <= cpu_prog_divider_r;
        if (wd_autorec_r)
          recov_n_r <= cpu_prog_multiplier_r;
      end
    end
  end
  // Strap capture at first low of power_good_n_i
  always @(posedge clk_i) begin
    if (rst_i) begin
      straps_r      <= 5'h00;
      straps_done_r <= 1'b0;
      rst_out_en_r  <= 1'b0;
    end else if (!straps_done_r && !power_good_n_i) begin
      straps_r      <= hardware_freq_straps_i;
      rst_out_en_r  <= ~reset_output_strap_i;
      straps_done_r <= 1'b1;
    end
  end
  // Operating selection outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      step_pins_r <= 2'b00;
      step_load_r <= 1'b0;
      entry_r     <= 5'h00;
      use_prog_r  <= 1'b0;
      step_r      <= 1'b0;
      cpu_n_r     <= 9'h000;
      cpu_m_r     <= 7'h00;
      src_act_r   <= 1'b0;
      src_n_r     <= 9'h000;
      sm_cpu_r    <= 1'b0;
      sm_src_r    <= 1'b0;
    end else begin
      step_pins_r <= overclock_step_pins_i;
      step_load_r <= dynamic_step_enable_r & (overclock_step_pins_i != step_pins_r);
      if (strap_override_r)
        entry_r <= {1'b0, soft_table_index_r};
      else
        entry_r <= straps_r;
      use_prog_r <= cpu_prog_en_r;
      step_r     <= dynamic_step_enable_r & (overclock_step_pins_i != 2'b00);
      if (dynamic_step_enable_r) begin
        case (overclock_step_pins_i)
          2'b01:   cpu_n_r <= step_multiplier_one_r;
          2'b10:   cpu_n_r <= step_multiplier_two_r;
          2'b11:   cpu_n_r <= step_multiplier_three_r;
          default: cpu_n_r <= cpu_prog_en_r ? cpu_prog_multiplier_r : 9'h000;
        endcase
      end else begin
        cpu_n_r <= cpu_prog_en_r ? cpu_prog_multiplier_r : 9'h000;
      end
      cpu_m_r   <= cpu_prog_en_r ? cpu_prog_divider_r : 7'h00;
      src_act_r <= src_prog_en_r;
      src_n_r   <= src_prog_en_r ? serial_ref_prog_multiplier_r : 9'h000;
      if (smooth_manual_r) begin
        sm_cpu_r <= ~smooth_src_r;
        sm_src_r <= smooth_src_r;
      end else begin
        sm_src_r <= src_prog_en_r & ~cpu_prog_en_r & ~dynamic_step_enable_r;
        sm_cpu_r <= ~(src_prog_en_r & ~cpu_prog_en_r & ~dynamic_step_enable_r);
      end
    end
  end
  ofsw_wdog #(
    .TICK_CYC  (TICK_CYC),
    .PULSE_CYC (PULSE_CYC)
  ) u_wdog (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .enable_i (watchdog_enable_r),
    .timer_i  (wd_timer_r),
    .scale_i  (wd_scale_r),
    .reload_i (wd_reload_r),
    .expire_o (wd_expire),
    .active_o (wd_active),
    .pulse_o  (wd_pulse)
  );
  assign wb_ack_o             = ack_r;
  assign wb_dat_o             = dat_r;
  assign cpu_table_entry_o    = entry_r;
  assign gear_sel_o           = straps_r;
  assign cpu_use_prog_o       = use_prog_r;
  assign cpu_step_o           = step_r;
  assign cpu_n_o              = cpu_n_r;
  assign cpu_m_o              = cpu_m_r;
  assign src_prog_active_o    = src_act_r;
  assign src_n_o              = src_n_r;
  assign step_load_o          = step_load_r;
  assign smooth_to_cpu_o      = sm_cpu_r;
  assign smooth_to_src_o      = sm_src_r;
  assign system_reset_out_n_o = ~(wd_pulse & rst_out_en_r);
endmodule

// File: hw/ofsw_wdog.v
// Watchdog countdown and system reset pulse timer
`timescale 1ns/1ps
`include "ofsw_consts.vh"
module ofsw_wdog #(
  parameter [`OFSW_CNT_W-1:0] TICK_CYC  = `OFSW_TICK_CYC,
  parameter [`OFSW_CNT_W-1:0] PULSE_CYC = `OFSW_PULSE_CYC
) (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       enable_i,
  input  wire [2:0] timer_i,
  input  wire       scale_i,
  input  wire       reload_i,
  output wire       expire_o,
  output wire       active_o,
  output wire       pulse_o
);
  localparam [6:0] MULT = `OFSW_SCALE_MULT;

  reg                   active_r;
  reg                   expire_r;
  reg                   pulse_r;
  reg [6:0]             units_r;
  reg [`OFSW_CNT_W-1:0] tick_r;
  reg [`OFSW_CNT_W-1:0] pcnt_r;

  // Number of scale units; the test code 000 runs a single unit
  function [6:0] load_units;
    input [2:0] t;
    input       s;
    begin
      if (t == 3'h0)
        load_units = 7'h01;
      else if (s)
        load_units = {4'h0, t} * MULT;
      else
        load_units = {4'h0, t};
    end
  endfunction

  always @(posedge clk_i) begin
    if (rst_i) begin
      active_r <= 1'b0;
      expire_r <= 1'b0;
      units_r  <= 7'h00;
      tick_r   <= {`OFSW_CNT_W{1'b0}};
    end else begin
      expire_r <= 1'b0;
      if (!enable_i) begin
        active_r <= 1'b0;
      end else if (reload_i) begin
        active_r <= 1'b1;
        units_r  <= load_units(timer_i, scale_i);
        tick_r   <= TICK_CYC - 1'b1;
      end else if (active_r) begin
        if (tick_r == {`OFSW_CNT_W{1'b0}}) begin
          tick_r  <= TICK_CYC - 1'b1;
          units_r <= units_r - 1'b1;
          if (units_r == 7'h01) begin
            active_r <= 1'b0;
            expire_r <= 1'b1;
          end
        end else begin
          tick_r <= tick_r - 1'b1;
        end
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      pulse_r <= 1'b0;
      pcnt_r  <= {`OFSW_CNT_W{1'b0}};
    end else if (expire_r) begin
      pulse_r <= 1'b1;
      pcnt_r  <= PULSE_CYC - 1'b1;
    end else if (pulse_r) begin
      if (pcnt_r == {`OFSW_CNT_W{1'b0}})
        pulse_r <= 1'b0;
      else
        pcnt_r <= pcnt_r - 1'b1;
    end
  end

  assign expire_o = expire_r;
  assign active_o = active_r;
  assign pulse_o  = pulse_r;
endmodule

// File: inc/ofsw_consts.vh
// Offsets, field positions, reset values and timing for the overclock watchdog block
`ifndef OFSW_CONSTS_VH
`define OFSW_CONSTS_VH

`define OFSW_ADR_CTRL      8'h00
`define OFSW_ADR_CPU_PROG  8'h04
`define OFSW_ADR_SRC_PROG  8'h08
`define OFSW_ADR_STEP1     8'h0c
`define OFSW_ADR_STEP2     8'h10
`define OFSW_ADR_STEP3     8'h14
`define OFSW_ADR_WD_CTRL   8'h18
`define OFSW_ADR_RECOV_N   8'h1c
`define OFSW_ADR_STATUS    8'h20
`define OFSW_ADR_STRAPS    8'h24

`define OFSW_B_OVERRIDE    0
`define OFSW_B_STEP_EN     1
`define OFSW_B_CPU_PROG    2
`define OFSW_B_SRC_PROG    3
`define OFSW_B_SM_MANUAL   4
`define OFSW_B_SM_SRC      5
`define OFSW_F_INDEX_LO    8
`define OFSW_F_M_LO        16

`define OFSW_B_WATCHDOG_ENABLE       0
`define OFSW_F_TIMER_LO    1
`define OFSW_B_SCALE       4
`define OFSW_B_RST_MODE    5
`define OFSW_B_REC_SRC     6
`define OFSW_B_AUTOREC     7
`define OFSW_B_ALARM       8

`define OFSW_RST_SCALE     1'b1
`define OFSW_RST_AUTOREC   1'b1
`define OFSW_RST_TIMER     3'h0

`define OFSW_CLK_KHZ       20000
`define OFSW_SCALE_LO_MS   250
`define OFSW_SCALE_HI_MS   3000
`define OFSW_PULSE_MS      20
`define OFSW_SCALE_MULT    7'h0c
`define OFSW_TICK_CYC      24'h4c4b40
`define OFSW_PULSE_CYC     24'h061a80
`define OFSW_CNT_W         24

`endif

// File: testbench/ofsw_host.sv
// Wishbone host model that programs the overclock watchdog registers
`timescale 1ns/1ps
`include "ofsw_consts.vh"
module ofsw_host (
  input  wire        clk_i,
  input  wire        ack_i,
  input  wire [31:0] dat_i,
  output reg         cyc_o,
  output reg         stb_o,
  output reg         we_o,
  output reg  [7:0]  adr_o,
  output reg  [3:0]  sel_o,
  output reg  [31:0] dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h0;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end
  // One classic cycle, held until ack is sampled high
  task xfer(input w, input [7:0] a, input [3:0] s, input [31:0] d, output [31:0] q);
    begin
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o  <= w;
      adr_o <= a;
      sel_o <= s;
      dat_o <= d;
      @(posedge clk_i);
      while (ack_i !== 1'b1) @(posedge clk_i);
      q = dat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      adr_o <= ~a;
      dat_o <= ~d;
      @(posedge clk_i);
    end
  endtask
  // Divider and multiplier always travel in one word
  task cpu_prog(input [8:0] n, input [6:0] m);
    reg [31:0] q;
    begin
      xfer(1'b1, `OFSW_ADR_CPU_PROG, 4'hf, {9'h0, m, 7'h0, n}, q);
    end
  endtask
endmodule

// File: testbench/ofsw_top_properties.sv
// Property checker for the overclock watchdog top level
`timescale 1ns/1ps
`include "ofsw_consts.vh"
module ofsw_top_chk #(
  parameter [`OFSW_CNT_W-1:0] TICK_CYC  = `OFSW_TICK_CYC,
  parameter [`OFSW_CNT_W-1:0] PULSE_CYC = `OFSW_PULSE_CYC
) (
  input wire       clk_i,
  input wire       rst_i,
  input wire       wb_cyc_i,
  input wire       wb_stb_i,
  input wire       wb_ack_o,
  input wire       power_good_n_i,
  input wire [1:0] overclock_step_pins_i,
  input wire [4:0] gear_sel_o,
  input wire       cpu_step_o,
  input wire       src_prog_active_o,
  input wire [8:0] src_n_o,
  input wire       step_load_o,
  input wire       smooth_to_cpu_o,
  input wire       smooth_to_src_o,
  input wire       system_reset_out_n_o
);
  reg [23:0] low_r;
  reg [3:0]  up_r;
  // Length of the current reset pulse and time since power good
  always @(posedge clk_i) begin
    if (rst_i) begin
      low_r <= 24'h0;
      up_r  <= 4'h0;
    end else begin
      low_r <= system_reset_out_n_o ? 24'h0 : low_r + 24'h1;
      if (!power_good_n_i && up_r != 4'hf) begin
        up_r <= up_r + 4'h1;
      end
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  chk_step_load_cause: assert property (step_load_o |->
    $past(overclock_step_pins_i) != $past(overclock_step_pins_i, 2))
    else $error("step load without pin change");
  chk_step_pins_set: assert property (cpu_step_o |->
    $past(overclock_step_pins_i) != 2'b00 || $past(overclock_step_pins_i, 2) != 2'b00)
    else $error("step active with pins at original");
  chk_smooth_one_owner: assert property (!$past(rst_i) |-> smooth_to_cpu_o ^ smooth_to_src_o)
    else $error("smooth circuit owner not unique");
  chk_pulse_length: assert property ($rose(system_reset_out_n_o) |-> low_r == PULSE_CYC)
    else $error("reset pulse length wrong");
  chk_src_idle_zero: assert property (!src_prog_active_o |-> src_n_o == 9'h0)
    else $error("serial N driven while disabled");
  chk_gear_stable: assert property (up_r > 4'h4 |-> $stable(gear_sel_o))
    else $error("gear select moved after capture");
  cov_step_load: cover property (step_load_o);
  cov_pulse: cover property ($fell(system_reset_out_n_o));
  cov_smooth_src: cover property (smooth_to_src_o);
endmodule
bind ofsw_top ofsw_top_chk #(.TICK_CYC(TICK_CYC), .PULSE_CYC(PULSE_CYC)) chk (
  .clk_i                 (clk_i),
  .rst_i                 (rst_i),
  .wb_cyc_i              (wb_cyc_i),
  .wb_stb_i              (wb_stb_i),
  .wb_ack_o              (wb_ack_o),
  .power_good_n_i        (power_good_n_i),
  .overclock_step_pins_i (overclock_step_pins_i),
  .gear_sel_o            (gear_sel_o),
  .cpu_step_o            (cpu_step_o),
  .src_prog_active_o     (src_prog_active_o),
  .src_n_o               (src_n_o),
  .step_load_o           (step_load_o),
  .smooth_to_cpu_o       (smooth_to_cpu_o),
  .smooth_to_src_o       (smooth_to_src_o),
  .system_reset_out_n_o  (system_reset_out_n_o)
);

// File: testbench/ofsw_top_test.sv
// Self-checking bench for the overclock watchdog top level
`timescale 1ns/1ps
`include "ofsw_consts.vh"
module ofsw_top_test;
  localparam [23:0] TICK = 24'd20;
  reg         clk_i   = 1'b0;
  reg         rst_i   = 1'b1;
  reg  [4:0]  straps  = 5'h0b;
  reg         strap_n = 1'b0;
  reg         pg_n    = 1'b1;
  reg  [1:0]  pins    = 2'b00;
  wire        cyc, stb, we, ack, use_prog, cpu_step, src_act, step_load, sm_cpu, sm_src, rst_out_n;
  wire [7:0]  adr;
  wire [3:0]  sel;
  wire [31:0] dat_w, dat_r;
  wire [4:0]  entry, gear;
  wire [8:0]  cpu_n, src_n;
  wire [6:0]  cpu_m;
  reg  [31:0] q;
  integer     n_errors = 0, check_count = 0, n_loads = 0, n_pulses = 0, i;
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (step_load === 1'b1) n_loads = n_loads + 1;
  always @(negedge rst_out_n) n_pulses = n_pulses + 1;
  ofsw_host host (.clk_i(clk_i), .ack_i(ack), .dat_i(dat_r), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(dat_w));
  ofsw_top #(.TICK_CYC(TICK), .PULSE_CYC(24'd10)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .hardware_freq_straps_i(straps), .reset_output_strap_i(strap_n),
    .power_good_n_i(pg_n), .overclock_step_pins_i(pins), .cpu_table_entry_o(entry), .gear_sel_o(gear),
    .cpu_use_prog_o(use_prog), .cpu_step_o(cpu_step), .cpu_n_o(cpu_n), .cpu_m_o(cpu_m),
    .src_prog_active_o(src_act), .src_n_o(src_n), .step_load_o(step_load), .smooth_to_cpu_o(sm_cpu),
    .smooth_to_src_o(sm_src), .system_reset_out_n_o(rst_out_n));
  task check(input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  task wr(input [7:0] a, input [31:0] d);
    host.xfer(1'b1, a, 4'hf, d, q);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      host.xfer(1'b0, a, 4'hf, 32'h0, q);
      check(q, e);
    end
  endtask
  // Arm the watchdog, optionally retime it, and time the expiry
  task expire(input [31:0] d1, input [31:0] d2, input integer units);
    integer c;
    begin
      wr(`OFSW_ADR_WD_CTRL, d1 & 32'hfffffffe);
      wr(`OFSW_ADR_WD_CTRL, d1);
      if (d2 != d1) begin
        host.cpu_prog(9'h060, 7'h20);
        tick(20);
        wr(`OFSW_ADR_WD_CTRL, d2);
      end
      c = 0;
      while (rst_out_n !== 1'b0 && c < 2000) begin
        @(posedge clk_i);
        c = c + 1;
      end
      check({31'h0, c >= units * TICK - 2 && c <= units * TICK + 4}, 32'h1);
      while (rst_out_n !== 1'b1) @(posedge clk_i);
      tick(3);
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    tick(4000);
    n_errors = n_errors + 1;
    stop_test;
  end
  initial begin
    tick(4);
    rst_i <= 1'b0;
    pg_n  <= 1'b0;
    rd(`OFSW_ADR_CTRL, 32'h0);
    rd(`OFSW_ADR_CPU_PROG, 32'h0);
    rd(`OFSW_ADR_SRC_PROG, 32'h0);
    rd(`OFSW_ADR_WD_CTRL, 32'h90);
    rd(`OFSW_ADR_STRAPS, 32'h6b);
    rd(`OFSW_ADR_STATUS, 32'h0100_0000);
    rd(8'h3c, 32'h0);
    check({31'h0, sm_cpu}, 32'h1);
    check({27'h0, entry}, 32'h0b);
    check({27'h0, gear}, 32'h0b);
    $display("test reset values done");
    for (i = 0; i < 16; i = i + 1) begin
      wr(`OFSW_ADR_CTRL, 32'h1 | (i << 8));
      tick(2);
      check({27'h0, entry}, i);
    end
    $display("test table index done");
    wr(`OFSW_ADR_CTRL, 32'h0);
    wr(`OFSW_ADR_CPU_PROG, 32'hffffffff);
    rd(`OFSW_ADR_CPU_PROG, 32'h007f01ff);
    host.xfer(1'b1, `OFSW_ADR_CPU_PROG, 4'h1, 32'h0, q);
    rd(`OFSW_ADR_CPU_PROG, 32'h007f0100);
    wr(`OFSW_ADR_SRC_PROG, 32'hffffffff);
    rd(`OFSW_ADR_SRC_PROG, 32'h1ff);
    check({src_act, src_n, cpu_m}, 32'h0);
    wr(`OFSW_ADR_CTRL, 32'hc);
    tick(2);
    check({use_prog, cpu_m, cpu_n, src_act, src_n}, {5'h0, 1'b1, 7'h7f, 9'h100, 1'b1, 9'h1ff});
    for (i = 0; i < 4; i = i + 1) begin
      wr(`OFSW_ADR_CTRL, {24'h0, 32'h38180_80c >> (i * 8)} & 32'hff);
      tick(2);
      check({sm_src, sm_cpu}, (8'h99 >> (i * 2)) & 2'h3);
    end
    $display("test programmable done");
    wr(`OFSW_ADR_CTRL, 32'h0);
    for (i = 1; i < 4; i = i + 1) wr(8'(`OFSW_ADR_STEP1 + 4 * i - 4), 32'h100 + i);
    pins <= 2'b01;
    tick(3);
    check(n_loads, 0);
    pins <= 2'b00;
    wr(`OFSW_ADR_CTRL, 32'h2);
    for (i = 1; i < 5; i = i + 1) begin
      pins <= 2'(i);
      tick(3);
      check({22'h0, cpu_step, cpu_n}, (i < 4) ? 32'h300 + i : 32'h0);
    end
    check(n_loads, 4);
    $display("test dynamic step done");
    wr(`OFSW_ADR_CTRL, 32'h0);
    host.cpu_prog(9'h050, 7'h10);
    wr(`OFSW_ADR_CTRL, 32'h4);
    expire(32'h85, 32'h87, 3);
    rd(`OFSW_ADR_RECOV_N, 32'h50);
    check({cpu_m, cpu_n}, {16'h0, 7'h10, 9'h050});
    rd(`OFSW_ADR_WD_CTRL, 32'h187);
    tick(240);
    wr(`OFSW_ADR_WD_CTRL, 32'h187);
    rd(`OFSW_ADR_WD_CTRL, 32'h87);
    tick(100);
    check(n_pulses, 1);
    host.cpu_prog(9'h061, 7'h21);
    expire(32'ha5, 32'ha7, 3);
    check({cpu_m, cpu_n}, {16'h0, 7'h20, 9'h060});
    wr(`OFSW_ADR_RECOV_N, 32'h1aa);
    rd(`OFSW_ADR_RECOV_N, 32'h61);
    wr(`OFSW_ADR_WD_CTRL, 32'h40);
    wr(`OFSW_ADR_RECOV_N, 32'h33);
    host.cpu_prog(9'h062, 7'h22);
    expire(32'h43, 32'h43, 1);
    check({cpu_m, cpu_n}, {16'h0, 7'h22, 9'h033});
    wr(`OFSW_ADR_CTRL, 32'h501);
    tick(2);
    check({27'h0, entry}, 32'h5);
    expire(32'h03, 32'h03, 1);
    check({26'h0, use_prog, entry}, 32'h0b);
    expire(32'h13, 32'h13, 12);
    $display("test watchdog done");
    stop_test;
  end
endmodule
